// ===== rtl/plcs_regs.sv
// Link capability, control and status registers with training tracker.
// Assumes a synchronous active-high reset, one 100 MHz clock, and a
// physical layer that reports training outcomes as one-cycle pulses.
//
// Design decision made here: the Avalon-MM interface to the registers.
`default_nettype none

module plcs_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Capability default load
  input wire logic strap_load_i,
  input wire plcs_pkg::plcs_strap_t strap_i,
  // Physical layer events
  input wire logic phy_train_ok_i,
  input wire logic phy_train_fail_i,
  input wire logic [5:0] phy_width_i,
  // Physical layer controls and interrupt
  output plcs_pkg::plcs_phy_ctl_t phy_ctl_o,
  output logic train_start_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  plcs_pkg::plcs_strap_t cap_q;
  logic [1:0] aspm_ctl_q;
  logic disable_q;
  logic retrain_q;
  logic cclk_q;
  logic extsync_q;
  logic [5:0] neg_width_q;
  logic train_err_q;
  plcs_pkg::plcs_state_t state_q;
  logic [plcs_pkg::IRQ_W-1:0] irq_sts_q;
  logic [plcs_pkg::IRQ_W-1:0] irq_msk_q;
  logic ack_q;
  logic req;
  logic wr_ctl;
  logic retrain_req;
  logic [plcs_pkg::IRQ_W-1:0] irq_evt;
  logic [31:0] cap_word;
  logic [31:0] ctl_sts_word;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle per access keeps read data registered
  assign req = avs_read_i | avs_write_i;
  assign wr_ctl = avs_write_i & ack_q & (avs_address_i == plcs_pkg::ADDR_LINK_CTL_STS) & avs_byteenable_i[0];
  assign retrain_req = wr_ctl & avs_writedata_i[plcs_pkg::CTL_RETRAIN];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(req & ~ack_q);
    end
  end

  // ----------------------------------------------------------------
  // Capability register
  // ----------------------------------------------------------------
  // Loaded defaults replace reset values; fields stay read-only to software
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cap_q <= '{plcs_pkg::ASPM_SUP_RST, plcs_pkg::L0S_LAT_RST, plcs_pkg::L1_LAT_RST};
    end else if (strap_load_i) begin
      cap_q <= strap_i;
    end
  end

  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[3:0] = plcs_pkg::SPEED_2G5;
    cap_word[9:4] = plcs_pkg::WIDTH_X1;
    cap_word[11:10] = cap_q.aspm_sup;
    cap_word[14:12] = cap_q.l0s_lat;
    cap_word[17:15] = cap_q.l1_lat;
    cap_word[31:24] = plcs_pkg::PORT_NUM;
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Retrain is self-clearing so software sees it as a request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aspm_ctl_q <= 2'h0;
      disable_q <= 1'b0;
      cclk_q <= 1'b0;
      extsync_q <= 1'b0;
    end else if (wr_ctl) begin
      aspm_ctl_q <= avs_writedata_i[plcs_pkg::CTL_ASPM_LO +: 2];
      disable_q <= avs_writedata_i[plcs_pkg::CTL_DISABLE];
      cclk_q <= avs_writedata_i[plcs_pkg::CTL_CCLK];
      extsync_q <= avs_writedata_i[plcs_pkg::CTL_EXTSYNC];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      retrain_q <= 1'b0;
    end else begin
      retrain_q <= retrain_req;
    end
  end

  // ----------------------------------------------------------------
  // Training tracker
  // ----------------------------------------------------------------
  // Disable dominates; retrain restarts training from any live state
  // Out of reset the tracker sits down one cycle so bit 27 resets to zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= plcs_pkg::PLCS_DOWN;
    end else if (disable_q) begin
      state_q <= plcs_pkg::PLCS_DOWN;
    end else if (retrain_q) begin
      state_q <= plcs_pkg::PLCS_TRAIN;
    end else begin
      unique case (state_q)
        plcs_pkg::PLCS_DOWN: state_q <= plcs_pkg::PLCS_TRAIN;
        plcs_pkg::PLCS_TRAIN: begin
          if (phy_train_ok_i) begin
            state_q <= plcs_pkg::PLCS_L0;
          end else if (phy_train_fail_i) begin
            state_q <= plcs_pkg::PLCS_ERR;
          end
        end
        plcs_pkg::PLCS_L0: state_q <= plcs_pkg::PLCS_L0;
        plcs_pkg::PLCS_ERR: state_q <= plcs_pkg::PLCS_TRAIN;
        default: state_q <= plcs_pkg::PLCS_DOWN;
      endcase
    end
  end

  // Error flag survives retries until a training succeeds
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      train_err_q <= 1'b0;
    end else if (state_q == plcs_pkg::PLCS_TRAIN && phy_train_fail_i && !phy_train_ok_i) begin
      train_err_q <= 1'b1;
    end else if (state_q == plcs_pkg::PLCS_TRAIN && phy_train_ok_i) begin
      train_err_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      neg_width_q <= 6'h00;
    end else if (state_q == plcs_pkg::PLCS_TRAIN && phy_train_ok_i) begin
      neg_width_q <= phy_width_i;
    end else if (state_q == plcs_pkg::PLCS_DOWN) begin
      neg_width_q <= 6'h00;
    end
  end

  always_comb begin
    ctl_sts_word = 32'h0000_0000;
    ctl_sts_word[1:0] = aspm_ctl_q;
    ctl_sts_word[plcs_pkg::CTL_DISABLE] = disable_q;
    ctl_sts_word[plcs_pkg::CTL_RETRAIN] = retrain_q;
    ctl_sts_word[plcs_pkg::CTL_CCLK] = cclk_q;
    ctl_sts_word[plcs_pkg::CTL_EXTSYNC] = extsync_q;
    ctl_sts_word[19:16] = plcs_pkg::SPEED_2G5;
    ctl_sts_word[25:20] = neg_width_q;
    ctl_sts_word[26] = train_err_q;
    ctl_sts_word[27] = (state_q == plcs_pkg::PLCS_TRAIN);
  end

  // ----------------------------------------------------------------
  // Physical layer controls
  // ----------------------------------------------------------------
  // Receiver L0s is never gated, not even in reset, so the enable resets high
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phy_ctl_o.l0s_en <= 1'b0;
      phy_ctl_o.l1_en <= 1'b0;
      phy_ctl_o.rx_l0s_en <= 1'b1;
      phy_ctl_o.common_clk <= 1'b0;
      phy_ctl_o.link_down <= 1'b0;
      phy_ctl_o.fts_count <= 13'h0000;
      phy_ctl_o.ts1_count <= 13'h0000;
      train_start_o <= 1'b0;
    end else begin
      phy_ctl_o.l0s_en <= aspm_ctl_q[0];
      phy_ctl_o.l1_en <= aspm_ctl_q[1];
      phy_ctl_o.rx_l0s_en <= 1'b1;
      phy_ctl_o.common_clk <= cclk_q;
      phy_ctl_o.link_down <= disable_q;
      phy_ctl_o.fts_count <= extsync_q ? plcs_pkg::FTS_EXT : plcs_pkg::FTS_NORMAL;
      phy_ctl_o.ts1_count <= extsync_q ? plcs_pkg::TS1_EXT : plcs_pkg::TS1_NORMAL;
      train_start_o <= retrain_q & ~disable_q;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_evt[plcs_pkg::IRQ_TRAIN_DONE] = (state_q == plcs_pkg::PLCS_TRAIN) & phy_train_ok_i;
  assign irq_evt[plcs_pkg::IRQ_TRAIN_ERR] = (state_q == plcs_pkg::PLCS_TRAIN) & phy_train_fail_i & ~phy_train_ok_i;
  assign irq_evt[plcs_pkg::IRQ_LINK_DOWN] = (state_q == plcs_pkg::PLCS_L0) & disable_q;

  // New events win over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_sts_q <= '0;
    end else if (avs_write_i && ack_q && avs_address_i == plcs_pkg::ADDR_IRQ_STATUS && avs_byteenable_i[0]) begin
      irq_sts_q <= (irq_sts_q & ~avs_writedata_i[plcs_pkg::IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_sts_q <= irq_sts_q | irq_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_msk_q <= '0;
    end else if (avs_write_i && ack_q && avs_address_i == plcs_pkg::ADDR_IRQ_MASK && avs_byteenable_i[0]) begin
      irq_msk_q <= avs_writedata_i[plcs_pkg::IRQ_W-1:0];
    end
  end

  // Registered output lags status by one cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_sts_q & irq_msk_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      unique case (avs_address_i)
        plcs_pkg::ADDR_LINK_CAP: avs_readdata_o <= cap_word;
        plcs_pkg::ADDR_LINK_CTL_STS: avs_readdata_o <= ctl_sts_word;
        plcs_pkg::ADDR_IRQ_STATUS: avs_readdata_o <= {29'h0000_0000, irq_sts_q};
        plcs_pkg::ADDR_IRQ_MASK: avs_readdata_o <= {29'h0000_0000, irq_msk_q};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ext_sync_fts: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    extsync_q |=> phy_ctl_o.fts_count == 13'h1000 && phy_ctl_o.ts1_count == 13'h0400)
    else $error("extended synch counts wrong");
  chk_aspm_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> phy_ctl_o.l0s_en == $past(aspm_ctl_q[0]) && phy_ctl_o.l1_en == $past(aspm_ctl_q[1]))
    else $error("aspm enables do not follow control");
  chk_rx_l0s_on: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(aspm_ctl_q) == 2'h0 |-> phy_ctl_o.rx_l0s_en)
    else $error("receiver l0s blocked");
  chk_train_err_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == plcs_pkg::PLCS_TRAIN && phy_train_fail_i && !phy_train_ok_i |=> train_err_q)
    else $error("training error not flagged");
  chk_train_err_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == plcs_pkg::PLCS_TRAIN && phy_train_ok_i |=> !train_err_q &&
      (state_q == plcs_pkg::PLCS_L0 || $past(disable_q) || $past(retrain_q)))
    else $error("training error not cleared on l0");
  chk_disable_down: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    disable_q |=> state_q == plcs_pkg::PLCS_DOWN ##1 phy_ctl_o.link_down || !disable_q)
    else $error("link not held down");
  chk_retrain_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    retrain_req && !disable_q |=> ##1 (state_q == plcs_pkg::PLCS_TRAIN && train_start_o) || disable_q)
    else $error("retrain did not start training");
  chk_cap_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cap_word[3:0] == 4'h1 && cap_word[9:4] == 6'h01 && cap_word[31:18] == 14'h0000)
    else $error("fixed capability fields wrong");
  chk_training_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctl_sts_word[27] |-> state_q == plcs_pkg::PLCS_TRAIN && ctl_sts_word[19:16] == 4'h1)
    else $error("training bit wrong");

  // Reset values, capture paths and interrupt plumbing
  chk_training_rst: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> !ctl_sts_word[27])
    else $error("training bit set out of reset");
  chk_cap_default: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> cap_q.aspm_sup == 2'b01 && cap_q.l0s_lat == 3'b011 && cap_q.l1_lat == 3'b000)
    else $error("capability defaults wrong after reset");
  chk_strap_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    strap_load_i |=> cap_q == $past(strap_i))
    else $error("loaded capability defaults not taken");
  chk_training_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == plcs_pkg::PLCS_TRAIN && phy_train_ok_i |=> !ctl_sts_word[27] || $past(retrain_q))
    else $error("training bit not cleared after training");
  chk_width_capture: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == plcs_pkg::PLCS_TRAIN && phy_train_ok_i |=> neg_width_q == $past(phy_width_i))
    else $error("negotiated width not captured");
  chk_down_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == plcs_pkg::PLCS_DOWN |=> neg_width_q == 6'h00)
    else $error("width not cleared while down");
  chk_cclk_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> phy_ctl_o.common_clk == $past(cclk_q) && phy_ctl_o.link_down == $past(disable_q))
    else $error("common clock or link down does not follow control");
  chk_irq_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    |irq_evt |=> (irq_sts_q & $past(irq_evt)) == $past(irq_evt))
    else $error("event did not set its status bit");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> irq_o == |($past(irq_sts_q) & $past(irq_msk_q)))
    else $error("interrupt level does not follow status and mask");

endmodule : plcs_regs

`default_nettype wire

// ===== rtl/plcs_pkg.sv
// Package for the link capability, control and status register bank.
// Assumes a single 100 MHz clock and an Avalon-MM register slave.
`default_nettype none

package plcs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LINK_CAP = 8'hec;
  localparam logic [7:0] ADDR_LINK_CTL_STS = 8'hf0;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf4;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hf8;

  // ----------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [1:0] ASPM_SUP_RST = 2'h1;
  localparam logic [2:0] L0S_LAT_RST = 3'h3;
  localparam logic [2:0] L1_LAT_RST = 3'h0;
  localparam logic [7:0] PORT_NUM = 8'h00;

  // Control field positions in the control half-word
  localparam int CTL_ASPM_LO = 0;
  localparam int CTL_DISABLE = 4;
  localparam int CTL_RETRAIN = 5;
  localparam int CTL_CCLK = 6;
  localparam int CTL_EXTSYNC = 7;

  // Interrupt status bits
  localparam int IRQ_TRAIN_DONE = 0;
  localparam int IRQ_TRAIN_ERR = 1;
  localparam int IRQ_LINK_DOWN = 2;
  localparam int IRQ_W = 3;

  // Ordered-set counts for exits
  localparam logic [12:0] FTS_NORMAL = 13'h00ff & 13'h1fff;
  localparam logic [12:0] FTS_EXT = 13'h1000;
  localparam logic [12:0] TS1_NORMAL = 13'h0010;
  localparam logic [12:0] TS1_EXT = 13'h0400;

  // Exit latency figures
  localparam int L0S_EXIT_NS = 256;
  localparam int L1_EXIT_US = 16;
  localparam int CLK_NS = 10;
  localparam int L0S_EXIT_CYC = (L0S_EXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int L1_EXIT_CYC = (L1_EXIT_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Link training state
  typedef enum logic [3:0] {
    PLCS_DOWN = 4'b0001,
    PLCS_TRAIN = 4'b0010,
    PLCS_L0 = 4'b0100,
    PLCS_ERR = 4'b1000
  } plcs_state_t;

  // Link-side request group toward the physical layer
  typedef struct packed {
    logic l0s_en;
    logic l1_en;
    logic rx_l0s_en;
    logic common_clk;
    logic link_down;
    logic [12:0] fts_count;
    logic [12:0] ts1_count;
  } plcs_phy_ctl_t;

  // Strap load of capability defaults
  typedef struct packed {
    logic [1:0] aspm_sup;
    logic [2:0] l0s_lat;
    logic [2:0] l1_lat;
  } plcs_strap_t;

endpackage : plcs_pkg

`default_nettype wire

// ===== test/plcs_phy_model.sv
// Behavioural link partner: answers each training attempt after a delay.
// Assumes the register bank drives train_start_o and phy_ctl_o.link_down.
`default_nettype none

module plcs_phy_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // From the register bank; fail_mode_i comes from the bench
  input wire logic train_start_i,
  input wire logic link_down_i,
  input wire logic fail_mode_i,
  // Training outcome
  output logic phy_train_ok_o,
  output logic phy_train_fail_o,
  output logic [5:0] phy_width_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  logic down_q;

  // ----------------------------------------------------------------
  // Training responder
  // ----------------------------------------------------------------
  // Re-armed by reset, retrain, own failure and link release
  always_ff @(posedge clk_i) begin
    phy_train_ok_o <= 1'b0;
    phy_train_fail_o <= 1'b0;
    down_q <= link_down_i;
    if (sys_rst_i || train_start_i || phy_train_fail_o || (down_q && !link_down_i)) begin
      cnt_q <= 8;
    end else if (link_down_i) begin
      cnt_q <= 0;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
      phy_train_ok_o <= (cnt_q == 1) && !fail_mode_i;
      phy_train_fail_o <= (cnt_q == 1) && fail_mode_i;
    end
  end

  // Lanes not driven while down: show a wrong pattern, not a stale one
  assign phy_width_o = link_down_i ? 6'h3e : 6'h01;
endmodule : plcs_phy_model

`default_nettype wire

// ===== test/tb_pcie_link_cap_ctrl_status_regs.sv
// Self-checking bench for the link capability/control/status bank.
// Assumes plcs_pkg, plcs_regs and the behavioural partner are compiled first.
`default_nettype none

module tb_pcie_link_cap_ctrl_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CAP = plcs_pkg::ADDR_LINK_CAP;
  localparam logic [7:0] A_CS = plcs_pkg::ADDR_LINK_CTL_STS;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic wreq;
  logic strap_load = 1'b0;
  plcs_pkg::plcs_strap_t strap = '0;
  logic ok;
  logic fail;
  logic fail_mode = 1'b0;
  logic [5:0] width;
  plcs_pkg::plcs_phy_ctl_t ctl;
  logic tstart;
  logic irq;
  logic [31:0] v;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  plcs_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .strap_load_i(strap_load), .strap_i(strap), .phy_train_ok_i(ok),
    .phy_train_fail_i(fail), .phy_width_i(width), .phy_ctl_o(ctl), .train_start_o(tstart),
    .irq_o(irq));

  plcs_phy_model phy (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .train_start_i(tstart),
    .link_down_i(ctl.link_down), .fail_mode_i(fail_mode), .phy_train_ok_o(ok),
    .phy_train_fail_o(fail), .phy_width_o(width));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One Avalon transfer; leading edge keeps back-to-back drives apart
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk_i);
    while (wreq !== 1'b0) @(posedge clk_i);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // Poll status until masked bits match; the timeout catches a hang
  task automatic poll(input logic [31:0] msk, input logic [31:0] val);
    for (int i = 0; i < 60; i++) begin
      bus(1'b0, A_CS, 32'h0000_0000, v);
      if ((v & msk) === val) break;
    end
    chk("status", v & msk, val);
  endtask : poll

  task automatic wait_start();
    for (int i = 0; i < 10 && tstart !== 1'b1; i++) @(posedge clk_i);
    chk("train_start", tstart, 1'b1);
  endtask : wait_start

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, A_CS, 32'h0, v);
    chk("training", v[27], 1'b1);
    chk("ctl_rst", v[15:0], 16'h0000);
    chk("rx_l0s", ctl.rx_l0s_en, 1'b1);
    bus(1'b1, A_CAP, 32'hffff_ffff, v);
    bus(1'b0, A_CAP, 32'h0, v);
    chk("cap", v, 32'h0000_3411);
    poll(32'hffff_0000, 32'h0011_0000);
    // Every ASPM code, receiver L0s always allowed
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, A_CS, m, v);
      bus(1'b0, A_CS, 32'h0, v);
      chk("aspm", v[1:0], m[1:0]);
      chk("aspm_en", {ctl.l1_en, ctl.l0s_en}, m[1:0]);
      chk("rx_l0s", ctl.rx_l0s_en, 1'b1);
    end
    // Common clock and extended synch both ways
    for (int e = 1; e >= 0; e--) begin
      bus(1'b1, A_CS, e ? 32'h0000_00c0 : 32'h0, v);
      bus(1'b0, A_CS, 32'h0, v);
      chk("cclk", {v[6], ctl.common_clk}, {2{e[0]}});
      chk("fts", ctl.fts_count, e ? plcs_pkg::FTS_EXT : plcs_pkg::FTS_NORMAL);
      chk("ts1", ctl.ts1_count, e ? plcs_pkg::TS1_EXT : plcs_pkg::TS1_NORMAL);
    end
    // Refused writes: lane 0 disabled, unmapped address
    be <= 4'h0;
    bus(1'b1, A_CS, 32'h0000_0040, v);
    be <= 4'hf;
    bus(1'b0, A_CS, 32'h0, v);
    chk("be_off", v[6], 1'b0);
    bus(1'b1, 8'h00, 32'hffff_ffff, v);
    bus(1'b0, 8'h00, 32'h0, v);
    chk("unmapped", v, 32'h0000_0000);
    // Interrupt: sticky, masked, then unmasked and cleared
    bus(1'b0, plcs_pkg::ADDR_IRQ_MASK, 32'h0, v);
    chk("mask_rst", v, 32'h0000_0000);
    bus(1'b0, plcs_pkg::ADDR_IRQ_STATUS, 32'h0, v);
    chk("irq_done", v[2:0], 3'b001);
    chk("irq_masked", irq, 1'b0);
    bus(1'b1, plcs_pkg::ADDR_IRQ_MASK, 32'h0000_0007, v);
    repeat (2) @(posedge clk_i);
    chk("irq_on", irq, 1'b1);
    bus(1'b1, plcs_pkg::ADDR_IRQ_STATUS, 32'h0000_0001, v);
    repeat (2) @(posedge clk_i);
    chk("irq_off", irq, 1'b0);
    // Retrain succeeds
    bus(1'b1, A_CS, 32'h0000_0020, v);
    wait_start();
    bus(1'b0, A_CS, 32'h0, v);
    chk("retrain", {v[27], v[5]}, 2'b10);
    poll(32'h0c30_0000, 32'h0010_0000);
    chk("irq_retrain", irq, 1'b1);
    bus(1'b1, plcs_pkg::ADDR_IRQ_STATUS, 32'h0000_0007, v);
    // Retrain fails, then the automatic retry succeeds
    fail_mode <= 1'b1;
    bus(1'b1, A_CS, 32'h0000_0020, v);
    wait_start();
    poll(32'h0400_0000, 32'h0400_0000);
    fail_mode <= 1'b0;
    poll(32'h0c00_0000, 32'h0000_0000);
    bus(1'b0, plcs_pkg::ADDR_IRQ_STATUS, 32'h0, v);
    chk("irq_err", v[1:0], 2'b11);
    // Link disable holds the link down until cleared
    bus(1'b1, A_CS, 32'h0000_0010, v);
    repeat (3) @(posedge clk_i);
    chk("link_down", ctl.link_down, 1'b1);
    repeat (20) @(posedge clk_i);
    bus(1'b0, A_CS, 32'h0, v);
    chk("down_width", v[25:20], 6'h00);
    bus(1'b0, plcs_pkg::ADDR_IRQ_STATUS, 32'h0, v);
    chk("irq_down", v[2], 1'b1);
    bus(1'b1, A_CS, 32'h0, v);
    poll(32'h0ff0_0000, 32'h0010_0000);
    // Loaded capability defaults replace the reset ones
    strap <= '{aspm_sup: 2'b10, l0s_lat: 3'b101, l1_lat: 3'b110};
    strap_load <= 1'b1;
    @(posedge clk_i);
    strap_load <= 1'b0;
    bus(1'b0, A_CAP, 32'h0, v);
    chk("cap_load", v, 32'h0003_5811);
    summarize();
  end
endmodule : tb_pcie_link_cap_ctrl_status_regs

`default_nettype wire
